// [bcw_top.sv]
// write-configuration command interpreter and configuration-driven pin control
//
// Contract
// - code 11h from the host is decoded as the write-configuration command.
// - bit 0 set runs third gpio pin; clear runs charge-detect output.
// - charge-detect pin drives the charging-supply comparator result for a power switch.
// - bit 1 set makes gpio pin a show inverted port-a buffer flag.
// - bit 2 set makes gpio pin b show inverted port-b buffer flag.
// - with flag enables set, a buffer write turns the pin pulldown on.
// - bit 3 enters pass-through; timer watches both ports; token pin outputs clock.
// - port falling edges restart timer; expiry ends pass-through and clears bit 3.
// - pass-through connects both port pins for uart traffic up to 512 kbps.
// - bit 4 enters quiet mode; timer watches primary port; token pin high, except in pass-through.
// - primary falling edge reloads timer; expiry ends quiet mode, clears bit 4.
// - bit 5 set connects weak pullup; clear connects weak pulldown instead, except in pass-through.
// - after the parameter, inverted crc-16 of command and parameter is returned.
// - commands are accepted only after bus reset and rom selection.
`timescale 1ns/100ps
`default_nettype none
`include "bcw_regs.svh"

module bcw_top #(
    parameter int TIMER_W = 8,
    parameter int TICK_CYCLES = (`BCW_TICK_NS + `BCW_CLK_PERIOD_NS - 1) / `BCW_CLK_PERIOD_NS,
    parameter int TOKEN_HALF_CYCLES = `BCW_TOKEN_HALF_NS / `BCW_CLK_PERIOD_NS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_reset,
    input wire logic rom_selected,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic [TIMER_W-1:0] timeout_value,
    input wire logic primary_port_pin,
    input wire logic secondary_port_pin,
    input wire logic charge_compare,
    input wire logic port_a_buffer_written_flag,
    input wire logic port_b_buffer_written_flag,
    input wire logic gpio_pin_a_normal_oe,
    input wire logic gpio_pin_b_normal_oe,
    input wire logic gpio_third_pin_normal_oe,
    input wire logic token_normal,
    output bcw_pkg::bcw_cfg_t config_value,
    output logic gpio_pin_a_oe,
    output logic gpio_pin_b_oe,
    output logic pin_c_out,
    output logic pin_c_oe,
    output logic token_pin,
    output logic passthrough_switch_on,
    output logic primary_pullup_on,
    output logic primary_pulldown_on
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int TOK_W = $clog2(TOKEN_HALF_CYCLES + 1);

    generate
        if (TICK_CYCLES < 1 || TOKEN_HALF_CYCLES < 1 || TIMER_W < 1) begin : g_bad_param
            $error("bcw_top: counts must be at least one");
        end
    endgenerate

    bcw_pkg::bcw_state_t state_r;
    bcw_pkg::bcw_cfg_t cfg_r;
    logic [15:0] crc;
    logic param_take;
    logic cmd_take;
    logic prim_m_r, prim_s_r, prim_d_r;
    logic sec_m_r, sec_s_r, sec_d_r;
    logic chg_m_r, chg_s_r;
    logic mode_active;
    logic act_edge;
    logic tick_done;
    logic expire;
    logic [TICK_W-1:0] tick_r;
    logic [TIMER_W-1:0] timer_r;
    logic [TOK_W-1:0] tok_div_r;
    logic tok_clk_r;

    assign cmd_take = (state_r == bcw_pkg::BCW_ST_CMD) && rx_valid && !bus_reset;
    assign param_take = (state_r == bcw_pkg::BCW_ST_PARAM) && rx_valid && !bus_reset;
    assign config_value = cfg_r;

    // -----------------------------------------------------------------
    // command sequence
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= bcw_pkg::BCW_ST_IDLE;
        end else if (bus_reset) begin
            state_r <= bcw_pkg::BCW_ST_ROM;
        end else begin
            unique case (state_r)
                bcw_pkg::BCW_ST_IDLE: begin
                end
                bcw_pkg::BCW_ST_ROM: begin
                    if (rom_selected) begin
                        state_r <= bcw_pkg::BCW_ST_CMD;
                    end
                end
                bcw_pkg::BCW_ST_CMD: begin
                    if (rx_valid) begin
                        // other codes belong to other command handlers
                        state_r <= (rx_byte == `BCW_CMD_WRITE_CONFIG) ? bcw_pkg::BCW_ST_PARAM
                                                                      : bcw_pkg::BCW_ST_DONE;
                    end
                end
                bcw_pkg::BCW_ST_PARAM: begin
                    if (rx_valid) begin
                        state_r <= bcw_pkg::BCW_ST_CRC_LO;
                    end
                end
                bcw_pkg::BCW_ST_CRC_LO: begin
                    if (tx_valid && tx_ready) begin
                        state_r <= bcw_pkg::BCW_ST_CRC_HI;
                    end
                end
                bcw_pkg::BCW_ST_CRC_HI: begin
                    if (tx_valid && tx_ready) begin
                        state_r <= bcw_pkg::BCW_ST_DONE;
                    end
                end
                bcw_pkg::BCW_ST_DONE: begin
                end
            endcase
        end
    end

    bcw_crc16 u_crc (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(bus_reset),
        .byte_valid(cmd_take || param_take),
        .byte_in(rx_byte),
        .crc(crc)
    );

    // crc bytes go out low byte first, inverted; the crc is settled one cycle after the parameter
    always_ff @(posedge clk_sys) begin
        if (rst || bus_reset) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else if (tx_valid) begin
            if (tx_ready) begin
                tx_valid <= 1'b0;
            end
        end else if (state_r == bcw_pkg::BCW_ST_CRC_LO) begin
            tx_valid <= 1'b1;
            tx_byte <= ~crc[7:0];
        end else if (state_r == bcw_pkg::BCW_ST_CRC_HI) begin
            tx_valid <= 1'b1;
            tx_byte <= ~crc[15:8];
        end
    end

    // -----------------------------------------------------------------
    // configuration register
    // -----------------------------------------------------------------
    // a fresh write wins over a timer expiry in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r <= `BCW_CFG_RESET;
        end else if (param_take) begin
            cfg_r <= rx_byte & `BCW_CFG_WRITE_MASK;
        end else if (expire) begin
            cfg_r.passthrough_enable <= 1'b0;
            cfg_r.quiet_enable <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {prim_m_r, prim_s_r, prim_d_r} <= 3'h7;
            {sec_m_r, sec_s_r, sec_d_r} <= 3'h7;
            {chg_m_r, chg_s_r} <= 2'h0;
        end else begin
            {prim_m_r, prim_s_r, prim_d_r} <= {primary_port_pin, prim_m_r, prim_s_r};
            {sec_m_r, sec_s_r, sec_d_r} <= {secondary_port_pin, sec_m_r, sec_s_r};
            {chg_m_r, chg_s_r} <= {charge_compare, chg_m_r};
        end
    end

    // -----------------------------------------------------------------
    // activity timer
    // -----------------------------------------------------------------
    assign mode_active = cfg_r.passthrough_enable || cfg_r.quiet_enable;
    assign act_edge = (prim_d_r && !prim_s_r)
                    || (cfg_r.passthrough_enable && sec_d_r && !sec_s_r);
    assign tick_done = (tick_r == TICK_W'(TICK_CYCLES - 1));
    assign expire = mode_active && !act_edge && tick_done && (timer_r == '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_r <= '0;
            timer_r <= '0;
        end else if (!mode_active || act_edge || param_take) begin
            tick_r <= '0;
            timer_r <= timeout_value;
        end else if (tick_done) begin
            tick_r <= '0;
            if (timer_r != '0) begin
                timer_r <= timer_r - 1'b1;
            end
        end else begin
            tick_r <= tick_r + 1'b1;
        end
    end

    // token clock runs only in pass-through, so it costs nothing otherwise
    always_ff @(posedge clk_sys) begin
        if (rst || !cfg_r.passthrough_enable) begin
            tok_div_r <= '0;
            tok_clk_r <= 1'b0;
        end else if (tok_div_r == TOK_W'(TOKEN_HALF_CYCLES - 1)) begin
            tok_div_r <= '0;
            tok_clk_r <= !tok_clk_r;
        end else begin
            tok_div_r <= tok_div_r + 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // pin control
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            token_pin <= 1'b0;
            passthrough_switch_on <= 1'b0;
        end else begin
            token_pin <= cfg_r.passthrough_enable ? tok_clk_r
                       : cfg_r.quiet_enable ? 1'b1 : token_normal;
            passthrough_switch_on <= cfg_r.passthrough_enable;
        end
    end

    // flag shown inverted on an open-drain pin: flag set pulls the pin low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpio_pin_a_oe <= 1'b0;
            gpio_pin_b_oe <= 1'b0;
        end else begin
            gpio_pin_a_oe <= cfg_r.port_a_flag_pin_enable ? port_a_buffer_written_flag
                                                          : gpio_pin_a_normal_oe;
            gpio_pin_b_oe <= cfg_r.port_b_flag_pin_enable ? port_b_buffer_written_flag
                                                          : gpio_pin_b_normal_oe;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_c_out <= 1'b0;
            pin_c_oe <= 1'b0;
        end else begin
            pin_c_out <= cfg_r.function_select ? 1'b0 : chg_s_r;
            pin_c_oe <= cfg_r.function_select ? gpio_third_pin_normal_oe : 1'b1;
        end
    end

    // pulldown is also dropped in pass-through so it does not load the link
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            primary_pullup_on <= 1'b0;
            primary_pulldown_on <= 1'b0;
        end else begin
            primary_pullup_on <= cfg_r.pullup_enable;
            primary_pulldown_on <= !cfg_r.pullup_enable && !cfg_r.passthrough_enable;
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_lo_sent;
        state_r == bcw_pkg::BCW_ST_CRC_LO && tx_valid && tx_ready && !bus_reset;
    endsequence
    sequence s_hi_offered;
        ##[1:2] (tx_valid && tx_byte == ~crc[15:8]);
    endsequence

    a_cmd_decode: assert property (cmd_take && rx_byte == `BCW_CMD_WRITE_CONFIG
        |=> state_r == bcw_pkg::BCW_ST_PARAM) else $error("write-config code not decoded");
    a_rom_gating: assert property (state_r == bcw_pkg::BCW_ST_ROM && !rom_selected && !bus_reset
        |=> state_r != bcw_pkg::BCW_ST_CMD) else $error("command phase without rom select");
    a_cfg_only_param: assert property ($changed(cfg_r) |-> $past(param_take) || $past(expire))
        else $error("config changed without parameter byte");
    a_crc_lo_out: assert property (param_take ##1 !bus_reset |=> tx_valid && tx_byte == ~crc[7:0])
        else $error("inverted crc low byte missing");
    a_crc_pair: assert property (s_lo_sent |-> s_hi_offered or (##1 bus_reset))
        else $error("crc high byte missing");
    a_expire_clears: assert property (expire && !param_take
        |=> !cfg_r.passthrough_enable && !cfg_r.quiet_enable) else $error("mode kept after expiry");
    a_edge_reload: assert property (mode_active && act_edge |=> timer_r == $past(timeout_value) && tick_r == '0)
        else $error("activity did not reload timer");
    a_token_quiet: assert property ((cfg_r.quiet_enable && !cfg_r.passthrough_enable) [*2] |-> token_pin)
        else $error("token not high in quiet mode");
    a_token_toggles: assert property (cfg_r.passthrough_enable && tok_div_r == TOK_W'(TOKEN_HALF_CYCLES - 1)
        |=> tok_clk_r != $past(tok_clk_r)) else $error("token clock stalled");
    a_flag_pin_a: assert property ((cfg_r.port_a_flag_pin_enable && port_a_buffer_written_flag) [*2]
        |-> gpio_pin_a_oe) else $error("pin a pulldown off with flag set");
    a_pull_exclusive: assert property (!(primary_pullup_on && primary_pulldown_on))
        else $error("pullup and pulldown both on");
    a_cd_follows: assert property (!cfg_r.function_select [*2] |-> pin_c_oe && pin_c_out == $past(chg_s_r))
        else $error("charge-detect output wrong");

endmodule // bcw_top
`default_nettype wire

// [bcw_regs.svh]
// constants of the bridge write-configuration command block
`ifndef BCW_REGS_SVH
`define BCW_REGS_SVH

// -----------------------------------------------------------------
// command codes and configuration layout
// -----------------------------------------------------------------
`define BCW_CMD_WRITE_CONFIG 8'h11
`define BCW_CFG_RESET 8'h00
`define BCW_CFG_WRITE_MASK 8'h3f

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define BCW_CLK_PERIOD_NS 8
`define BCW_TICK_NS 1000
`define BCW_TOKEN_HALF_NS 976
`define BCW_PT_MAX_KBPS 512

// -----------------------------------------------------------------
// crc-16, reflected form, sent inverted
// -----------------------------------------------------------------
`define BCW_CRC_POLY 16'ha001
`define BCW_CRC_INIT 16'h0000

`endif

// [bcw_pkg.sv]
// types of the bridge write-configuration command block
package bcw_pkg;

    // -----------------------------------------------------------------
    // configuration register fields, bit 0 first from the right
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] reserved;
        logic pullup_enable;
        logic quiet_enable;
        logic passthrough_enable;
        logic port_b_flag_pin_enable;
        logic port_a_flag_pin_enable;
        logic function_select;
    } bcw_cfg_t;

    // -----------------------------------------------------------------
    // command sequence states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        BCW_ST_IDLE,
        BCW_ST_ROM,
        BCW_ST_CMD,
        BCW_ST_PARAM,
        BCW_ST_CRC_LO,
        BCW_ST_CRC_HI,
        BCW_ST_DONE
    } bcw_state_t;

endpackage

// [bcw_crc16.sv]
// byte-wide crc-16 accumulator
`timescale 1ns/100ps
`default_nettype none
`include "bcw_regs.svh"

module bcw_crc16 (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    output logic [15:0] crc
);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c;
        for (int i = 0; i < 8; i++) begin
            if (v[0] ^ d[i]) begin
                v = (v >> 1) ^ `BCW_CRC_POLY;
            end else begin
                v = v >> 1;
            end
        end
        return v;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            crc <= `BCW_CRC_INIT;
        end else if (byte_valid) begin
            crc <= crc_byte(crc, byte_in);
        end
    end

endmodule // bcw_crc16
`default_nettype wire

// [bcw_host_model.sv]
// host controller model driving the byte-level command link
`timescale 1ns/100ps
`default_nettype none

module bcw_host_model (
    input wire logic clk_sys,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic bus_reset,
    output logic rom_selected,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    initial begin
        bus_reset = 1'b0;
        rom_selected = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end

    // -----------------------------------------------------------------
    // byte transfers
    // -----------------------------------------------------------------
    task automatic put(input logic [7:0] b);
        @(negedge clk_sys);
        bus_reset = 1'b0;
        rom_selected = 1'b0;
        rx_valid = 1'b1;
        rx_byte = b;
    endtask

    task automatic get(input int stall, output logic [7:0] b, output bit ok);
        int n;
        ok = 0;
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk_sys);
            if (tx_valid === 1'b1) ok = 1;
        end
        // a slow host leaves the byte offered for a while
        repeat (stall) @(negedge clk_sys);
        b = tx_byte;
        tx_ready = 1'b1;
        @(negedge clk_sys);
        tx_ready = 1'b0;
    endtask

    // -----------------------------------------------------------------
    // whole command sequence; with_par low aborts by a bus reset
    // -----------------------------------------------------------------
    task automatic run(input logic rom, input logic [7:0] cmd, input logic [7:0] par, input logic with_par,
                       input logic get_crc, input int stall, output logic [15:0] crc, output bit ok);
        bit ok2;
        logic [7:0] lo;
        logic [7:0] hi;
        @(negedge clk_sys);
        bus_reset = 1'b1;
        @(negedge clk_sys);
        bus_reset = 1'b0;
        rom_selected = rom;
        put(cmd);
        if (with_par) begin
            put(par);
        end else begin
            @(negedge clk_sys);
            rx_valid = 1'b0;
            rx_byte = ~rx_byte;
            bus_reset = 1'b1;
        end
        @(negedge clk_sys);
        rx_valid = 1'b0;
        // released data line no longer shows the last byte
        rx_byte = ~rx_byte;
        bus_reset = 1'b0;
        crc = 16'h0000;
        ok = 1;
        if (get_crc) begin
            get(stall, lo, ok);
            get(0, hi, ok2);
            ok = ok & ok2;
            crc = {hi, lo};
        end
    endtask
endmodule // bcw_host_model
`default_nettype wire

// [bcw_top_tb.sv]
// self-checking testbench of the write-configuration block
`timescale 1ns/100ps
`default_nettype none
`include "bcw_regs.svh"

module bcw_top_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic bus_reset, rom_selected, rx_valid, tx_ready, tx_valid;
    logic [7:0] rx_byte, tx_byte;
    logic [7:0] timeout_value = 8'h28;
    logic prim = 1'b1;
    logic sec = 1'b1;
    logic chg = 1'b1, flag_a = 1'b1, flag_b = 1'b0, norm_a = 1'b0, norm_b = 1'b1;
    bcw_pkg::bcw_cfg_t config_value;
    logic gpio_pin_a_oe, gpio_pin_b_oe, pin_c_out, pin_c_oe, token_pin;
    logic passthrough_switch_on, primary_pullup_on, primary_pulldown_on;
    logic [7:0] pins;
    int fails = 0;
    int samples_checked = 0;
    logic [15:0] crc;
    bit ok;
    logic t0;
    // rows: parameter, expected configuration, expected pin vector
    logic [23:0] rows [7] = '{24'h000074, 24'h010154, 24'h0202f4, 24'h040434, 24'h202078, 24'hc70794, 24'h101075};
    // refusals: rom, command, parameter present
    logic [9:0] bad [3] = '{10'h245, 10'h023, 10'h222};

    always #4 clk_sys = ~clk_sys;
    assign pins = {gpio_pin_a_oe, gpio_pin_b_oe, pin_c_out, pin_c_oe, primary_pullup_on, primary_pulldown_on,
                   passthrough_switch_on, token_pin};

    bcw_host_model bcw_host_model_i (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .bus_reset(bus_reset), .rom_selected(rom_selected), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_ready(tx_ready));

    bcw_top #(.TICK_CYCLES(2), .TOKEN_HALF_CYCLES(2)) bcw_top_i (.clk_sys(clk_sys), .rst(rst),
        .bus_reset(bus_reset), .rom_selected(rom_selected), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .timeout_value(timeout_value),
        .primary_port_pin(prim), .secondary_port_pin(sec), .charge_compare(chg),
        .port_a_buffer_written_flag(flag_a), .port_b_buffer_written_flag(flag_b),
        .gpio_pin_a_normal_oe(norm_a), .gpio_pin_b_normal_oe(norm_b), .gpio_third_pin_normal_oe(1'b1),
        .token_normal(1'b0), .config_value(config_value), .gpio_pin_a_oe(gpio_pin_a_oe),
        .gpio_pin_b_oe(gpio_pin_b_oe), .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe), .token_pin(token_pin),
        .passthrough_switch_on(passthrough_switch_on), .primary_pullup_on(primary_pullup_on),
        .primary_pulldown_on(primary_pulldown_on));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] crc16(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] c;
        logic [15:0] d;
        c = `BCW_CRC_INIT;
        d = {b, a};
        for (int i = 0; i < 16; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ `BCW_CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] p, input int stall);
        bcw_host_model_i.run(1'b1, `BCW_CMD_WRITE_CONFIG, p, 1'b1, 1'b1, stall, crc, ok);
        check("crc handshake", ok, 1'b1);
    endtask

    // a low pulse long enough for the two-flop synchroniser
    task automatic fall(input bit on_sec);
        @(negedge clk_sys);
        if (on_sec) sec = 1'b0; else prim = 1'b0;
        repeat (4) @(negedge clk_sys);
        sec = 1'b1;
        prim = 1'b1;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        fails++;
        end_of_test();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_sys);
        check("reset config", config_value, 8'h00);
        check("reset tx_valid", tx_valid, 1'b0);
        rst = 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        check("pulldown after reset", primary_pulldown_on, 1'b1);
        check("pin_c_oe after reset", pin_c_oe, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wr(rows[i][23:16], (i % 2) * 3);
            // pullup writes skip the checksum comparison
            if (!rows[i][21]) check("crc", crc, crc16(`BCW_CMD_WRITE_CONFIG, rows[i][23:16]));
            check("config", config_value, rows[i][15:8]);
            check("pins", pins, rows[i][7:0]);
        end
        // flags and normal enables moved away from the row defaults
        wr(8'h06, 0);
        {flag_a, flag_b, norm_a, norm_b} = 4'b0110;
        repeat (2) @(negedge clk_sys);
        check("flag pins", {gpio_pin_a_oe, gpio_pin_b_oe}, 2'b01);
        wr(8'h00, 0);
        chg = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("normal pins", {gpio_pin_a_oe, gpio_pin_b_oe, pin_c_out}, 3'b100);
        // refused sequences leave the configuration alone
        wr(8'h02, 0);
        for (int i = 0; i < 3; i++) begin
            bcw_host_model_i.run(bad[i][9], bad[i][8:1], 8'h3f, bad[i][0], 1'b0, 0, crc, ok);
            repeat (4) @(negedge clk_sys);
            check("refused config", config_value, 8'h02);
            check("refused tx", tx_valid, 1'b0);
        end
        // quiet mode: reload by primary edges, then expiry
        wr(8'h10, 0);
        repeat (60) @(negedge clk_sys);
        check("qm held", config_value, 8'h10);
        fall(0);
        repeat (56) @(negedge clk_sys);
        check("qm reloaded", config_value, 8'h10);
        check("qm token", token_pin, 1'b1);
        repeat (120) @(negedge clk_sys);
        check("qm expired", config_value, 8'h00);
        check("token normal", token_pin, 1'b0);
        // pass-through: clock on token, secondary edges reload
        wr(8'h08, 2);
        check("pt switch", {passthrough_switch_on, primary_pulldown_on}, 2'b10);
        t0 = token_pin;
        repeat (2) @(negedge clk_sys);
        check("pt token toggles", token_pin, !t0);
        repeat (58) @(negedge clk_sys);
        fall(1);
        repeat (56) @(negedge clk_sys);
        check("pt reloaded", config_value, 8'h08);
        repeat (120) @(negedge clk_sys);
        check("pt expired", config_value, 8'h00);
        check("pt switch off", {passthrough_switch_on, primary_pulldown_on}, 2'b01);
        // reset in mid-run clears the register
        wr(8'h02, 0);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("mid reset config", config_value, 8'h00);
        check("mid reset a_oe", gpio_pin_a_oe, 1'b0);
        rst = 1'b0;
        // first command right after release must still be served
        wr(8'h01, 0);
        check("config after mid reset", config_value, 8'h01);
        end_of_test();
    end
endmodule // bcw_top_tb
`default_nettype wire
